// [hw/watchdog_nmi_reset_timer.sv]
// Watchdog timer with NMI, grace period, system reset and freeze controls
//
// Overview of operation
// [RULE_01] Count down by one on every 10.24 ms tick unless frozen.
// [RULE_02] Counter starts at 255 after any reset.
// [RULE_03] Software keeps write guard bits zero when reloading the counter.
// [RULE_04] A counter write with any guard bit set is dropped.
// [RULE_05] Past zero the counter goes negative through its sign bit.
// [RULE_06] Interrupt mode: NMI at zero, system reset at or below -16.
// [RULE_07] NMI handler reloads above -16 before sixteen more ticks pass.
// [RULE_08] Reset mode: system reset at or below zero, no NMI.
// [RULE_09] Watchdog reset reinitialises the block, counter back to 255.
// [RULE_10] Boot remap selection survives watchdog reset; restart from address zero.
// [RULE_11] Debug halt stops counting; software cannot mask it.
// [RULE_12] Debug enable bit is not reachable by software.
// [RULE_13] Software freeze set works only while reset mode is off.
// [RULE_14] Software freeze clear write resumes counting.
// [RULE_15] Reset mode bit is set-only; only system reset clears it.
// [RULE_16] While frozen the counter holds and nothing fires.
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_params.svh"

module watchdog_nmi_reset_timer
  import watchdog_pkg::*;
#(
  parameter int TICK_CYCLES = `WDT_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_strobe,
  input  wire logic        rd_strobe,
  output logic      [31:0] rdata,
  // Debug module status
  input  wire logic        debug_halted,
  input  wire logic        debug_enable_bit,
  // System outputs
  output logic             nmi,
  output logic             sys_reset,
  output logic             irq,
  output logic [`WDT_REMAP_W-1:0] boot_remap_select
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  // The divider needs at least two states to form a pulse
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  // Reset threshold must sit below zero, or the grace period vanishes
  if ($signed(`WDT_GRACE_LIMIT) >= 0) begin : g_bad_limit
    $error("grace limit must be negative");
  end

  // Signed compare used for every expiry threshold
  function automatic logic at_or_below(
    input logic [8:0] value,
    input logic [8:0] limit
  );
    return $signed(value) <= $signed(limit);
  endfunction : at_or_below

  // Address decode shared by all register writes
  function automatic logic hit(
    input logic [7:0] a,
    input logic [7:0] ofs
  );
    return a == ofs;
  endfunction : hit

  // Counter, time base, phase and register state
  logic [8:0]            count;
  logic [TW-1:0]         div;
  logic                  tick;
  phase_t                phase;
  phase_t                next_phase;
  logic                  nmi_rst;
  logic                  sw_frozen;
  logic                  dbg_freeze;
  logic                  dbg_freeze_q;
  logic                  frozen;
  logic                  sys_init;
  logic                  wr_count;
  logic                  guard_ok;
  logic                  nmi_now;
  logic                  wdog_caused;
  logic [`WDT_EV_W-1:0]  irq_stat;
  logic [`WDT_EV_W-1:0]  irq_mask;
  logic [`WDT_EV_W-1:0]  events;
  logic [`WDT_EV_W-1:0]  clr_bits;

  // Fire state stands for the system reset of the block, all but boot remap and reset cause
  assign sys_init = (phase == PH_FIRE); // RULE_09

  // Debug freeze: enable comes from the debug module only, no register
  assign dbg_freeze = debug_halted & debug_enable_bit; // RULE_11 RULE_12

  // Software freeze holds only while reset mode is off, so a freeze set
  // before reset mode was chosen cannot keep the system reset away
  assign frozen = dbg_freeze | (sw_frozen & ~nmi_rst); // RULE_13 RULE_16

  // Counter write decode and guard filter
  assign wr_count = wr_strobe & hit(addr, `WDT_OFS_COUNT);
  assign guard_ok = (wdata[`WDT_GUARD_MSB:`WDT_GUARD_LSB] == 7'h00); // RULE_04

  // Tick pulse at the end of each divider period
  assign tick = (div == TICK_LAST);

  // Time base divider, restarted by the watchdog reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div <= '0;
    end else if (sys_init || tick) begin
      div <= '0;
    end else begin
      div <= div + TW'(1); // RULE_01
    end
  end

  // Timeout counter; a guarded write beats a tick in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= `WDT_CNT_RESET; // RULE_02
    end else if (sys_init) begin
      count <= `WDT_CNT_RESET; // RULE_09
    end else if (wr_count && guard_ok) begin
      count <= wdata[8:0];
    end else if (tick && !frozen) begin
      count <= count - 9'h001; // RULE_01 RULE_05 RULE_16
    end
  end

  // Expiry phase; armed and grace hold while frozen, fire always returns to armed
  always_comb begin
    next_phase = phase;
    case (phase)
      PH_ARMED: begin
        if (!frozen) begin // RULE_16
          if (nmi_rst && at_or_below(count, `WDT_CNT_ZERO)) begin
            next_phase = PH_FIRE; // RULE_08
          end else if (at_or_below(count, `WDT_GRACE_LIMIT)) begin
            next_phase = PH_FIRE; // RULE_06
          end else if (at_or_below(count, `WDT_CNT_ZERO)) begin
            next_phase = PH_GRACE; // RULE_06
          end
        end
      end
      PH_GRACE: begin
        if (!frozen) begin // RULE_16
          if (at_or_below(count, `WDT_GRACE_LIMIT)) begin
            next_phase = PH_FIRE; // RULE_06
          end else if (nmi_rst && at_or_below(count, `WDT_CNT_ZERO)) begin
            next_phase = PH_FIRE; // RULE_08
          end else if (!at_or_below(count, `WDT_CNT_ZERO)) begin
            next_phase = PH_ARMED; // RULE_07
          end
        end
      end
      PH_FIRE: begin
        next_phase = PH_ARMED;
      end
      default: begin
        next_phase = PH_ARMED;
      end
    endcase
  end

  // Phase register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= PH_ARMED;
    end else begin
      phase <= next_phase;
    end
  end

  // NMI only on entry into the grace period
  assign nmi_now = (phase == PH_ARMED) && (next_phase == PH_GRACE);

  // One-cycle NMI and system reset pulses
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nmi       <= 1'b0;
      sys_reset <= 1'b0;
    end else begin
      nmi       <= nmi_now; // RULE_06
      sys_reset <= (next_phase == PH_FIRE); // RULE_06 RULE_08 RULE_09
    end
  end

  // Reset-mode bit: software can only set it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nmi_rst <= 1'b0;
    end else if (sys_init) begin
      nmi_rst <= 1'b0; // RULE_15
    end else if (wr_strobe && hit(addr, `WDT_OFS_CTRL) && wdata[`WDT_CTRL_NMI_RST]) begin
      nmi_rst <= 1'b1; // RULE_15
    end
  end

  // Software freeze; set is refused in reset mode so it cannot mask a reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_frozen <= 1'b0;
    end else if (sys_init) begin
      sw_frozen <= 1'b0;
    end else if (wr_strobe && hit(addr, `WDT_OFS_FRZ_SET) && wdata[`WDT_FRZ_BIT] && !nmi_rst) begin
      sw_frozen <= 1'b1; // RULE_13
    end else if (wr_strobe && hit(addr, `WDT_OFS_FRZ_CLR) && wdata[`WDT_FRZ_BIT]) begin
      sw_frozen <= 1'b0; // RULE_14
    end
  end

  // Edge detect on the debug freeze for its event
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dbg_freeze_q <= 1'b0;
    end else begin
      dbg_freeze_q <= dbg_freeze;
    end
  end

  // Event sources of the sticky status
  always_comb begin
    events = '0;
    events[`WDT_EV_NMI]   = nmi_now;
    events[`WDT_EV_DBG]   = dbg_freeze & ~dbg_freeze_q;
    events[`WDT_EV_GUARD] = wr_count & ~guard_ok;
  end

  // Write-one-to-clear bits of the status register
  assign clr_bits = (wr_strobe && hit(addr, `WDT_OFS_IRQ_ST)) ? wdata[`WDT_EV_W-1:0] : '0;

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat <= '0;
    end else if (sys_init) begin
      irq_stat <= events;
    end else begin
      irq_stat <= (irq_stat & ~clr_bits) | events;
    end
  end

  // Interrupt mask
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask <= '0;
    end else if (sys_init) begin
      irq_mask <= '0;
    end else if (wr_strobe && hit(addr, `WDT_OFS_IRQ_MSK)) begin
      irq_mask <= wdata[`WDT_EV_W-1:0];
    end
  end

  // Level interrupt while any unmasked status bit is set
  assign irq = |(irq_stat & irq_mask);

  // Boot remap and reset cause live on the hardware reset only,
  // so the core restarts at address zero of the same memory
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      boot_remap_select <= '0;
      wdog_caused       <= 1'b0;
    end else begin
      if (wr_strobe && hit(addr, `WDT_OFS_REMAP)) begin
        boot_remap_select <= wdata[`WDT_REMAP_W-1:0]; // RULE_10
      end
      if (sys_init) begin
        wdog_caused <= 1'b1; // RULE_10
      end
    end
  end

  // Read data for exactly one cycle after the strobe, zero otherwise
  // Write-only freeze registers fall to the default and read as zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 32'h0000_0000;
    end else if (!rd_strobe) begin
      rdata <= 32'h0000_0000;
    end else begin
      case (addr)
        `WDT_OFS_COUNT:   rdata <= {23'h00_0000, count};
        `WDT_OFS_CTRL:    rdata <= {31'h0000_0000, nmi_rst};
        `WDT_OFS_STATE:   rdata <= {26'h000_0000, wdog_caused, phase, dbg_freeze, sw_frozen};
        `WDT_OFS_IRQ_ST:  rdata <= {29'h0000_0000, irq_stat};
        `WDT_OFS_IRQ_MSK: rdata <= {29'h0000_0000, irq_mask};
        `WDT_OFS_REMAP:   rdata <= {30'h0000_0000, boot_remap_select};
        default:          rdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : watchdog_nmi_reset_timer
`default_nettype wire

// [pkg/watchdog_params.svh]
// Offsets, field positions, reset values and timing counts of the watchdog
`ifndef WATCHDOG_PARAMS_SVH
`define WATCHDOG_PARAMS_SVH

// Clock and tick timing
`define WDT_CLK_PERIOD_NS  40
`define WDT_TICK_PERIOD_NS 10240000
`define WDT_TICK_CYCLES    (`WDT_TICK_PERIOD_NS / `WDT_CLK_PERIOD_NS)

// Register byte offsets
`define WDT_OFS_COUNT   8'h00
`define WDT_OFS_CTRL    8'h04
`define WDT_OFS_FRZ_SET 8'h08
`define WDT_OFS_FRZ_CLR 8'h0C
`define WDT_OFS_STATE   8'h10
`define WDT_OFS_IRQ_ST  8'h14
`define WDT_OFS_IRQ_MSK 8'h18
`define WDT_OFS_REMAP   8'h1C

// Counter values, two's complement over nine bits
`define WDT_CNT_RESET   9'h0FF
`define WDT_CNT_ZERO    9'h000
`define WDT_GRACE_LIMIT 9'h1F0

// Field positions
`define WDT_GUARD_MSB   15
`define WDT_GUARD_LSB   9
`define WDT_CTRL_NMI_RST 0
`define WDT_FRZ_BIT     0
`define WDT_EV_NMI      0
`define WDT_EV_DBG      1
`define WDT_EV_GUARD    2
`define WDT_EV_W        3
`define WDT_REMAP_W     2

`endif

// [pkg/watchdog_pkg.sv]
// Types shared by the watchdog design
`default_nettype none
package watchdog_pkg;

  // Expiry phase of the watchdog
  typedef enum logic [2:0] {
    PH_ARMED = 3'b001,
    PH_GRACE = 3'b010,
    PH_FIRE  = 3'b100
  } phase_t;

endpackage : watchdog_pkg
`default_nettype wire

// [verification/watchdog_nmi_reset_timer_properties.sv]
// Port-level properties of the watchdog timer
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_params.svh"
module watchdog_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Register port
  input wire logic [7:0]  addr,
  input wire logic        wr_strobe,
  input wire logic        rd_strobe,
  input wire logic [31:0] rdata,
  // Debug and system
  input wire logic        debug_halted,
  input wire logic        debug_enable_bit,
  input wire logic        nmi,
  input wire logic        sys_reset,
  input wire logic        irq,
  input wire logic [1:0]  boot_remap_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Halt held with no software write in between
  sequence halt3;
    (debug_halted && debug_enable_bit && !wr_strobe)[*3];
  endsequence

  a_rdata_idle: assert property (!rd_strobe |=> rdata == 32'h0000_0000) else $error("rdata not idle");
  a_rdata_upper: assert property (rd_strobe |=> rdata[31:9] == 23'h0) else $error("rdata upper bits set");
  a_nmi_pulse: assert property (nmi |=> !nmi) else $error("nmi longer than one cycle");
  a_grace_wait: assert property (nmi |=> !sys_reset[*8]) else $error("reset too soon after nmi");
  a_reset_pulse: assert property (sys_reset |=> !sys_reset) else $error("reset pulse too long");
  a_reset_reload: assert property (sys_reset |=> (!nmi && !irq)[*2]) else $error("state not reloaded");
  a_debug_hold: assert property (halt3 |-> !nmi && !sys_reset) else $error("fired while halted");
  a_remap_kept: assert property (!(wr_strobe && addr == `WDT_OFS_REMAP) |=> $stable(boot_remap_select))
    else $error("remap changed");
endmodule : watchdog_checker
bind watchdog_nmi_reset_timer watchdog_checker u_chk (.clk(clk), .rst_b(rst_b), .addr(addr),
  .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata), .debug_halted(debug_halted),
  .debug_enable_bit(debug_enable_bit), .nmi(nmi), .sys_reset(sys_reset), .irq(irq),
  .boot_remap_select(boot_remap_select));
`default_nettype wire

// [verification/watchdog_nmi_reset_timer_tb_top.sv]
// Self-checking bench for the watchdog timer
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_params.svh"
module watchdog_nmi_reset_timer_tb_top;
  localparam int T = 4;
  logic clk, rst_b, wr_strobe, rd_strobe, debug_halted, debug_enable_bit, nmi, sys_reset, irq;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, rv, v;
  logic [1:0]  boot_remap_select;
  int          err_total, checks, n, nmi_cnt, n0;
  time         t0;

  // Short tick keeps the run brief
  watchdog_nmi_reset_timer #(.TICK_CYCLES(T)) uut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata), .debug_halted(debug_halted),
    .debug_enable_bit(debug_enable_bit), .nmi(nmi), .sys_reset(sys_reset), .irq(irq),
    .boot_remap_select(boot_remap_select));

  // 40 ns clock
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  // Running count of interrupt pulses; scenarios compare differences
  always @(posedge clk) if (nmi === 1'b1) nmi_cnt <= nmi_cnt + 1;

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_strobe <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_strobe <= 0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    rd_strobe <= 1;
    addr <= a;
    @(posedge clk);
    rd_strobe <= 0;
    #1;
    rv = rdata;
  endtask : rd

  // Bounded wait; a pulse is caught since every cycle is looked at
  task automatic wt(input bit s, output int k);
    k = 0;
    while ((s ? sys_reset : nmi) !== 1'b1 && k < 200) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask : wt

  task automatic s_basic;
    rd(`WDT_OFS_COUNT);
    chk(rv, 32'h0000_00FF);
    rd(8'h40);
    chk(rv, 32'h0000_0000);
    wr(`WDT_OFS_REMAP, 32'h0000_0002);
    chk({30'h0, boot_remap_select}, 32'h0000_0002);
  endtask : s_basic

  task automatic s_count;
    wr(`WDT_OFS_COUNT, 32'h0000_0080);
    rd(`WDT_OFS_COUNT);
    v = rv;
    repeat (T - 2) @(posedge clk);
    rd(`WDT_OFS_COUNT);
    chk(v - rv, 32'h0000_0001);
    wr(`WDT_OFS_COUNT, 32'h0000_FE20);
    rd(`WDT_OFS_COUNT);
    chk({29'h0, rv[8:6]}, 32'h0000_0001);
    rd(`WDT_OFS_IRQ_ST);
    chk({31'h0, rv[2]}, 32'h0000_0001);
    wr(`WDT_OFS_IRQ_ST, 32'h0000_0007);
  endtask : s_count

  task automatic s_freeze;
    @(posedge clk);
    debug_halted <= 1;
    debug_enable_bit <= 1;
    rd(`WDT_OFS_COUNT);
    v = rv;
    repeat (3 * T) @(posedge clk);
    rd(`WDT_OFS_COUNT);
    chk(rv, v);
    @(posedge clk);
    debug_enable_bit <= 0;
    rd(`WDT_OFS_COUNT);
    v = rv;
    repeat (2 * T) @(posedge clk);
    rd(`WDT_OFS_COUNT);
    chk({31'h0, rv < v}, 32'h0000_0001);
    @(posedge clk);
    debug_halted <= 0;
    wr(`WDT_OFS_FRZ_SET, 32'h0000_0001);
    rd(`WDT_OFS_COUNT);
    v = rv;
    repeat (3 * T) @(posedge clk);
    rd(`WDT_OFS_COUNT);
    chk(rv, v);
    wr(`WDT_OFS_FRZ_CLR, 32'h0000_0001);
    repeat (2 * T) @(posedge clk);
    rd(`WDT_OFS_COUNT);
    chk({31'h0, rv < v}, 32'h0000_0001);
  endtask : s_freeze

  task automatic s_grace;
    n0 = nmi_cnt;
    wr(`WDT_OFS_IRQ_MSK, 32'h0000_0001);
    wr(`WDT_OFS_COUNT, 32'h0000_0001);
    wt(0, n);
    t0 = $time;
    chk({31'h0, irq}, 32'h0000_0001);
    repeat (2 * T) @(posedge clk);
    rd(`WDT_OFS_COUNT);
    chk({27'h0, rv[8:4]}, 32'h0000_001F);
    wr(`WDT_OFS_IRQ_ST, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    wt(1, n);
    chk(32'(($time - t0) / 40), 16 * T);
    chk(nmi_cnt - n0, 32'h0000_0001);
    rd(`WDT_OFS_COUNT);
    chk(rv, 32'h0000_00FF);
    chk({30'h0, boot_remap_select}, 32'h0000_0002);
    wr(`WDT_OFS_COUNT, 32'h0000_0001);
    wt(0, n);
    wr(`WDT_OFS_COUNT, 32'h0000_00FF);
    wt(1, n);
    chk(n, 200);
  endtask : s_grace

  task automatic s_rst_mode;
    wr(`WDT_OFS_CTRL, 32'h0000_0001);
    wr(`WDT_OFS_CTRL, 32'h0000_0000);
    rd(`WDT_OFS_CTRL);
    chk(rv, 32'h0000_0001);
    wr(`WDT_OFS_FRZ_SET, 32'h0000_0001);
    rd(`WDT_OFS_STATE);
    chk({31'h0, rv[0]}, 32'h0000_0000);
    n0 = nmi_cnt;
    wr(`WDT_OFS_COUNT, 32'h0000_0001);
    wt(1, n);
    chk({31'h0, n <= T + 1}, 32'h0000_0001);
    chk(nmi_cnt - n0, 32'h0000_0000);
    rd(`WDT_OFS_CTRL);
    chk(rv, 32'h0000_0000);
  endtask : s_rst_mode

  task automatic close_out;
    $display("Checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    {rst_b, wr_strobe, rd_strobe, debug_halted, debug_enable_bit} = '0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    err_total = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1;
    s_basic;
    s_count;
    s_freeze;
    s_grace;
    s_rst_mode;
    close_out;
  end

  // Hang guard, well past the expected run
  initial begin
    #(40 * 5000);
    err_total++;
    close_out;
  end
endmodule : watchdog_nmi_reset_timer_tb_top
`default_nettype wire
